// ---- bench/bmc_master_model.sv ----
// Upstream two-wire bus master model for the register block bench.
`timescale 1ns/100ps
`default_nettype none
module bmc_master_model (
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// Data moves only while the clock is low, so no false start or stop.
	task automatic slot(input logic b, output logic s);
		scl_o = 1'b0;
		#100 sda_oe_o = !b;
		#100 scl_o = 1'b1;
		#100 s = sda_i;
		#100;
	endtask
	// The ninth slot is always released: write ack or read not-ack.
	task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			slot(d[i], q[i]);
		slot(1'b1, s);
		ack = !s;
	endtask
	task automatic xfer(input logic [6:0] a, input logic rw,
		input logic [7:0] p, input logic wd, input logic [7:0] d,
		output logic [7:0] q, output logic ack);
		logic k;
		sda_oe_o = 1'b1;
		#200 byte_io({a, rw}, q, ack);
		if (ack)
			byte_io(rw ? 8'hff : p, q, k);
		if (ack && wd)
			byte_io(d, q, k);
		scl_o = 1'b0;
		#100 sda_oe_o = 1'b1;
		#100 scl_o = 1'b1;
		#100 sda_oe_o = 1'b0;
		#200;
	endtask
endmodule
`default_nettype wire

// ---- bench/bmc_monitor.sv ----
// Port assertions for the configuration register block.
`timescale 1ns/100ps
`default_nettype none
module bmc_monitor (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic upstream_clock_line_i,
	input wire logic upstream_data_line_o,
	input wire logic [3:0] channel_fault_inputs_n_i,
	input wire logic [3:0] channel_switch_state_o,
	input wire logic buffer_enable_o,
	input wire logic connected_o,
	input wire logic alert_n_o,
	input wire logic [1:0] gpio_o,
	input wire logic [1:0] gpio_oe_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	a_off_switch_open: assert property (
		!enable_i [*4] |-> channel_switch_state_o == 4'h0)
		else $error("switch closed while disabled");
	a_off_pins_float: assert property (
		!enable_i [*5] |-> gpio_oe_o == 2'h0)
		else $error("pin driven while disabled");
	a_fault_alert_low: assert property (
		(channel_fault_inputs_n_i != 4'hf) [*4] |-> !alert_n_o)
		else $error("fault not passed on");
	a_buffer_needs_switch: assert property (
		buffer_enable_o |-> $past(channel_switch_state_o) != 4'h0)
		else $error("buffer on with no switch");
	a_ready_tracks_buffer: assert property (
		connected_o == buffer_enable_o)
		else $error("ready and buffer differ");
	a_cut_raises_alert: assert property (
		$fell(buffer_enable_o) && channel_switch_state_o != 4'h0
		|-> ##[0:2] !alert_n_o)
		else $error("path cut without alert");
	a_switch_scl_low: assert property (
		$changed(channel_switch_state_o) |->
		!upstream_clock_line_i || channel_switch_state_o == 4'h0)
		else $error("switch moved outside a bit slot");
	a_pins_open_drain: assert property (
		upstream_data_line_o == 1'b0 && gpio_o == 2'h3)
		else $error("fixed pin value changed");
	c_closed: cover property (buffer_enable_o);
	c_cut: cover property ($fell(buffer_enable_o) && !alert_n_o);
	c_fault: cover property (!alert_n_o && !enable_i);
endmodule
bind bmc_config_regs bmc_monitor u_mon (
	.clock_i, .reset_n_i, .enable_i, .upstream_clock_line_i,
	.upstream_data_line_o, .channel_fault_inputs_n_i,
	.channel_switch_state_o, .buffer_enable_o, .connected_o,
	.alert_n_o, .gpio_o, .gpio_oe_o);
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the configuration register block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam logic [6:0] DEV = 7'h4a;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic enable_i = 1'b1;
	logic [3:0] idle = 4'hf;
	logic [3:0] fault_n = 4'hf;
	logic node_low = 1'b0;
	logic [3:0] sw;
	logic buf_en, alert_n, dut_oe, scl, m_oe, ack;
	logic [1:0] gpio_oe;
	logic [7:0] r, v;
	int fail_count = 0;
	int checks = 0;
	// Pull-up on the data line; both parties only ever pull it low.
	wire logic sda = !(dut_oe || m_oe);
	always #25 clock_i = ~clock_i;
	bmc_config_regs #(.DEV_ADDR(DEV), .TMO_30_CYC(40), .TMO_15_CYC(20),
		.TMO_7P5_CYC(10)) u_dut (.clock_i, .reset_n_i, .enable_i,
		.upstream_clock_line_i(scl), .upstream_data_line_i(sda),
		.upstream_data_line_o(), .upstream_data_line_oe_o(dut_oe),
		.channel_idle_high_i(idle), .channel_fault_inputs_n_i(fault_n),
		.bus_node_low_i(node_low), .channel_switch_state_o(sw),
		.buffer_enable_o(buf_en), .connected_o(), .alert_n_o(alert_n),
		.gpio_o(), .gpio_oe_o(gpio_oe));
	bmc_master_model u_mst (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic check(input string n, input logic [7:0] s, e);
		checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] p, d, input logic [6:0] a = DEV);
		u_mst.xfer(a, 1'b0, p, 1'b1, d, r, ack);
	endtask
	// Reads return the last pointed register, so point first.
	task automatic rd(input logic [7:0] p);
		u_mst.xfer(DEV, 1'b0, p, 1'b0, 8'h00, r, ack);
		u_mst.xfer(DEV, 1'b1, p, 1'b0, 8'h00, r, ack);
	endtask
	function automatic logic [7:0] oe_exp(input logic [7:0] c);
		return {6'h00, ~c[6] & c[3], ~c[7] & c[4]};
	endfunction
	initial
	begin
		logic [3:0] q;
		v = 8'($urandom(5));
		tick(8);
		reset_n_i = 1'b1;
		tick(4);
		rd(bmc_pkg::REG_CONFIG);
		check("config", r, bmc_pkg::CFG_RESET);
		check("pin enable", {6'h00, gpio_oe}, 8'h00);
		idle = 4'($urandom);
		rd(bmc_pkg::REG_CONNECT);
		check("connect", r, {4'h0, idle});
		rd(8'h07);
		check("unmapped", r, 8'h00);
		repeat (6)
		begin
			v = 8'($urandom);
			wr(bmc_pkg::REG_CONFIG, v);
			rd(bmc_pkg::REG_CONFIG);
			check("config", r, v);
			check("pin enable", {6'h00, gpio_oe}, oe_exp(v));
		end
		for (int p = 0; p < 2; p++)
		begin
			wr(bmc_pkg::REG_CONFIG, p[0] ? 8'h24 : 8'h04);
			idle = 4'($urandom) & 4'h7;
			q = p[0] ? 4'hf : 4'($urandom) | 4'h8;
			v = {4'h0, p[0] ? q : q & idle};
			wr(bmc_pkg::REG_CONNECT, {q, 4'h0});
			tick(2);
			check("switch", {4'h0, sw}, v);
			check("alert", {7'h00, alert_n}, {7'h00, p[0]});
			idle = ~idle;
			tick(4);
			check("switch held", {4'h0, sw}, v);
			wr(bmc_pkg::REG_STATUS, 8'h00);
		end
		wr(bmc_pkg::REG_CONNECT, 8'ha0, bmc_pkg::BCAST_ADDR);
		check("broadcast", {4'h0, sw}, 8'h0a);
		wr(bmc_pkg::REG_CONFIG, 8'h20);
		wr(bmc_pkg::REG_CONNECT, 8'h50, bmc_pkg::BCAST_ADDR);
		check("broadcast off", {3'h0, ack, sw}, 8'h0a);
		for (int k = 0; k < 4; k++)
		begin
			wr(bmc_pkg::REG_CONFIG, 8'h20 | 8'(k));
			wr(bmc_pkg::REG_STATUS, 8'h00);
			node_low = 1'b1;
			tick(k == 0 ? 60 : k == 1 ? 36 : k == 2 ? 16 : 6);
			node_low = 1'b0;
			tick(3);
			check("buffer", {7'h00, buf_en}, 8'h01);
			if (k > 0)
			begin
				node_low = 1'b1;
				tick(k == 1 ? 46 : k == 2 ? 26 : 16);
				check("cut", {6'h00, buf_en, alert_n}, 8'h00);
				check("switch kept", {4'h0, sw}, 8'h0a);
				rd(bmc_pkg::REG_STATUS);
				check("status", r, 8'hff);
				node_low = 1'b0;
			end
		end
		wr(bmc_pkg::REG_STATUS, 8'h00);
		enable_i = 1'b0;
		fault_n = 4'hb;
		tick(5);
		check("disabled", {sw, 3'h0, alert_n}, 8'h00);
		wr(bmc_pkg::REG_CONNECT, 8'hf0);
		check("ignored", {3'h0, ack, sw}, 8'h00);
		fault_n = 4'hf;
		enable_i = 1'b1;
		tick(4);
		rd(bmc_pkg::REG_CONFIG);
		check("config", r, bmc_pkg::CFG_RESET);
		check("alert clear", {7'h00, alert_n}, 8'h01);
		stop_test();
	end
	initial
	begin
		#2_000_000;
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire

// ---- rtl/bmc_config_regs.sv ----
// Configuration and connection registers of a four-channel bus multiplexer.
`timescale 1ns/100ps
`default_nettype none
module bmc_config_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h4a, // Arbitrary default address.
	parameter int TMO_30_CYC = bmc_pkg::TMO_30_CYC,
	parameter int TMO_15_CYC = bmc_pkg::TMO_15_CYC,
	parameter int TMO_7P5_CYC = bmc_pkg::TMO_7P5_CYC
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic enable_i,
	input wire logic upstream_clock_line_i,
	input wire logic upstream_data_line_i,
	output logic upstream_data_line_o,
	output logic upstream_data_line_oe_o,
	input wire logic [3:0] channel_idle_high_i,
	input wire logic [3:0] channel_fault_inputs_n_i,
	input wire logic bus_node_low_i,
	output logic [3:0] channel_switch_state_o,
	output logic buffer_enable_o,
	output logic connected_o,
	output logic alert_n_o,
	output logic [1:0] gpio_o,
	output logic [1:0] gpio_oe_o
);

	logic [11:0] sync1_q;
	logic [11:0] sync2_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic en;
	logic scl;
	logic sda;
	logic [3:0] idle;
	logic [3:0] fault_n;
	logic bus_low;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic tmo_now;

	bmc_pkg::bmc_state_t state_q;
	bmc_pkg::bmc_state_t state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] ptr_q;
	logic [7:0] ptr_d;
	logic rw_q;
	logic rw_d;
	logic nack_q;
	logic nack_d;
	logic sda_oe_q;
	logic sda_oe_d;
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic [3:0] chan_q;
	logic [3:0] chan_d;
	logic conn_ok_q;
	logic conn_ok_d;
	logic latched_q;
	logic latched_d;
	logic buf_en_q;
	logic conn_q;
	logic alert_n_q;
	logic [1:0] gpio_oe_q;
	logic [1:0] gpio_q;

	// Pins from outside are only read after the second flop.
	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
		begin
			sync1_q <= bmc_pkg::SYNC_RESET;
			sync2_q <= bmc_pkg::SYNC_RESET;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			sync1_q <= {enable_i, upstream_clock_line_i, upstream_data_line_i,
				channel_idle_high_i, channel_fault_inputs_n_i, bus_node_low_i};
			sync2_q <= sync1_q;
			scl_prev_q <= sync2_q[10];
			sda_prev_q <= sync2_q[9];
		end
	end

	assign en = sync2_q[11];
	assign scl = sync2_q[10];
	assign sda = sync2_q[9];
	assign idle = sync2_q[8:5];
	assign fault_n = sync2_q[4:1];
	assign bus_low = sync2_q[0];
	assign scl_rise = scl && !scl_prev_q;
	assign scl_fall = !scl && scl_prev_q;
	assign start_seen = scl && scl_prev_q && sda_prev_q && !sda;
	assign stop_seen = scl && scl_prev_q && !sda_prev_q && sda;

	bmc_stuck_timer #(
		.CYC_30(TMO_30_CYC),
		.CYC_15(TMO_15_CYC),
		.CYC_7P5(TMO_7P5_CYC)
	) u_timer (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.run_i(en && (cfg_q[1:0] != bmc_pkg::TMO_OFF)),
		.bus_low_i(bus_low),
		.select_i(cfg_q[bmc_pkg::CFG_TMO_HI:bmc_pkg::CFG_TMO_LO]),
		.expired_o(tmo_now)
	);

	function automatic logic addr_match(input logic [7:0] b,
		input logic bcast_en);
		addr_match = (b[7:1] == DEV_ADDR) ||
			(bcast_en && !b[0] && b[7:1] == bmc_pkg::BCAST_ADDR);
	endfunction

	function automatic logic [7:0] read_byte(input logic [7:0] p);
		if (p == bmc_pkg::REG_STATUS)
			read_byte = {(|chan_q), fault_n, conn_ok_q, latched_q, tmo_now};
		else if (p == bmc_pkg::REG_CONFIG)
			read_byte = cfg_q;
		else if (p == bmc_pkg::REG_CONNECT)
			read_byte = {chan_q, idle};
		else
			read_byte = 8'h00;
	endfunction

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		nack_d = nack_q;
		sda_oe_d = sda_oe_q;
		cfg_d = cfg_q;
		chan_d = chan_q;
		conn_ok_d = conn_ok_q;
		latched_d = latched_q;
		if (!en)
		begin
			// Held at defaults and deaf to the bus while disabled.
			state_d = bmc_pkg::ST_IDLE;
			sda_oe_d = 1'b0;
			cfg_d = bmc_pkg::CFG_RESET;
			chan_d = bmc_pkg::CHAN_RESET;
			conn_ok_d = 1'b1;
			latched_d = 1'b0;
		end
		else if (start_seen)
		begin
			state_d = bmc_pkg::ST_ADDR;
			cnt_d = 4'h0;
			sda_oe_d = 1'b0;
		end
		else if (stop_seen)
		begin
			state_d = bmc_pkg::ST_IDLE;
			sda_oe_d = 1'b0;
		end
		else
		begin
			case (state_q)
				bmc_pkg::ST_ADDR, bmc_pkg::ST_PTR, bmc_pkg::ST_WDATA:
				begin
					if (scl_rise)
					begin
						sh_d = {sh_q[6:0], sda};
						cnt_d = cnt_q + 4'h1;
					end
					else if (scl_fall && cnt_q == bmc_pkg::BYTE_BITS)
					begin
						cnt_d = 4'h0;
						sda_oe_d = 1'b1;
						if (state_q == bmc_pkg::ST_ADDR)
						begin
							rw_d = sh_q[0];
							state_d = bmc_pkg::ST_ACK_A;
							if (!addr_match(sh_q, cfg_q[bmc_pkg::CFG_BCAST]))
							begin
								sda_oe_d = 1'b0;
								state_d = bmc_pkg::ST_IDLE;
							end
						end
						else if (state_q == bmc_pkg::ST_PTR)
						begin
							ptr_d = sh_q;
							state_d = bmc_pkg::ST_ACK_P;
						end
						else
						begin
							state_d = bmc_pkg::ST_ACK_W;
							if (ptr_q == bmc_pkg::REG_CONFIG)
								cfg_d = sh_q;
							else if (ptr_q == bmc_pkg::REG_CONNECT)
							begin
								// Requested channels are judged one by one.
								chan_d = sh_q[7:4] &
									(cfg_q[bmc_pkg::CFG_POLICY] ? 4'hf : idle);
								if (!cfg_q[bmc_pkg::CFG_POLICY] &&
									(|(sh_q[7:4] & ~idle)))
									conn_ok_d = 1'b0;
							end
							else if (ptr_q == bmc_pkg::REG_STATUS)
							begin
								conn_ok_d = 1'b1;
								latched_d = 1'b0;
							end
						end
					end
				end
				bmc_pkg::ST_ACK_A:
				begin
					if (scl_fall)
					begin
						cnt_d = 4'h0;
						sda_oe_d = 1'b0;
						state_d = bmc_pkg::ST_PTR;
						if (rw_q)
						begin
							sh_d = read_byte(ptr_q);
							sda_oe_d = !sh_d[7];
							state_d = bmc_pkg::ST_RDATA;
						end
					end
				end
				bmc_pkg::ST_ACK_P, bmc_pkg::ST_ACK_W:
				begin
					if (scl_fall)
					begin
						cnt_d = 4'h0;
						sda_oe_d = 1'b0;
						state_d = bmc_pkg::ST_WDATA;
					end
				end
				bmc_pkg::ST_RDATA:
				begin
					if (scl_rise)
						cnt_d = cnt_q + 4'h1;
					else if (scl_fall && cnt_q == bmc_pkg::BYTE_BITS)
					begin
						sda_oe_d = 1'b0;
						state_d = bmc_pkg::ST_RACK;
					end
					else if (scl_fall)
					begin
						sh_d = {sh_q[6:0], 1'b0};
						sda_oe_d = !sh_q[6];
					end
				end
				bmc_pkg::ST_RACK:
				begin
					if (scl_rise)
						nack_d = sda;
					else if (scl_fall)
					begin
						cnt_d = 4'h0;
						state_d = bmc_pkg::ST_IDLE;
						if (!nack_q)
						begin
							sh_d = read_byte(ptr_q);
							sda_oe_d = !sh_d[7];
							state_d = bmc_pkg::ST_RDATA;
						end
					end
				end
				default:
				begin
					state_d = bmc_pkg::ST_IDLE;
					sda_oe_d = 1'b0;
				end
			endcase
			// A timeout in the clearing cycle still latches.
			if (tmo_now)
				latched_d = 1'b1;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= bmc_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b1;
			sda_oe_q <= 1'b0;
			cfg_q <= bmc_pkg::CFG_RESET;
			chan_q <= bmc_pkg::CHAN_RESET;
			conn_ok_q <= 1'b1;
			latched_q <= 1'b0;
			buf_en_q <= 1'b0;
			conn_q <= 1'b0;
			alert_n_q <= 1'b1;
			gpio_oe_q <= 2'h0;
			gpio_q <= bmc_pkg::GPIO_LEVEL;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			sda_oe_q <= sda_oe_d;
			cfg_q <= cfg_d;
			chan_q <= chan_d;
			conn_ok_q <= conn_ok_d;
			latched_q <= latched_d;
			// Switch bits are kept; the buffers, connected_o and alert_n_o drop on timeout.
			buf_en_q <= (|chan_q) && !latched_q;
			conn_q <= (|chan_q) && !latched_q;
			alert_n_q <= (&fault_n) && conn_ok_q && !latched_q;
			// Output level stays high, so open-drain never pulls down.
			gpio_oe_q <= {!cfg_q[bmc_pkg::CFG_DIR2] &&
				cfg_q[bmc_pkg::CFG_DRIVE2],
				!cfg_q[bmc_pkg::CFG_DIR1] &&
				cfg_q[bmc_pkg::CFG_DRIVE1]};
			gpio_q <= bmc_pkg::GPIO_LEVEL;
		end
	end

	assign upstream_data_line_o = 1'b0;
	assign upstream_data_line_oe_o = sda_oe_q;
	assign channel_switch_state_o = chan_q;
	assign buffer_enable_o = buf_en_q;
	assign connected_o = conn_q;
	assign alert_n_o = alert_n_q;
	assign gpio_o = gpio_q;
	assign gpio_oe_o = gpio_oe_q;

endmodule
`default_nettype wire

// ---- rtl/bmc_pkg.sv ----
// Shared constants of the bus multiplexer configuration register block.
package bmc_pkg;

	// Register pointer values seen on the upstream two-wire bus.
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h02;
	localparam logic [7:0] REG_CONNECT = 8'h03;

	// Field positions of the switch_config register.
	localparam int CFG_DIR1 = 7;
	localparam int CFG_DIR2 = 6;
	localparam int CFG_POLICY = 5;
	localparam int CFG_DRIVE1 = 4;
	localparam int CFG_DRIVE2 = 3;
	localparam int CFG_BCAST = 2;
	localparam int CFG_TMO_HI = 1;
	localparam int CFG_TMO_LO = 0;

	// Reset values.
	localparam logic [7:0] CFG_RESET = 8'h04;
	localparam logic [3:0] CHAN_RESET = 4'h0;
	localparam logic [1:0] GPIO_LEVEL = 2'h3;
	// Synchroniser reset has both bus lines high, no fault and no node low, so no false edge or alert.
	localparam logic [11:0] SYNC_RESET = 12'h61e;

	// Fixed seven-bit broadcast write address.
	localparam logic [6:0] BCAST_ADDR = 7'h5d;

	// Timeout field encodings.
	localparam logic [1:0] TMO_OFF = 2'h0;
	localparam logic [1:0] TMO_SEL_30 = 2'h1;
	localparam logic [1:0] TMO_SEL_15 = 2'h2;

	// Stuck-low times in microseconds and the clock rate.
	localparam int CLK_KHZ = 20000;
	localparam int TMO_30_US = 30000;
	localparam int TMO_15_US = 15000;
	localparam int TMO_7P5_US = 7500;
	localparam int TMO_30_CYC = TMO_30_US * CLK_KHZ / 1000;
	localparam int TMO_15_CYC = TMO_15_US * CLK_KHZ / 1000;
	localparam int TMO_7P5_CYC = TMO_7P5_US * CLK_KHZ / 1000;
	localparam int TMO_CNT_W = 20;

	// Bit counter value after a full byte.
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Two-wire slave states.
	typedef enum logic [8:0] {
		ST_IDLE = 9'b0_0000_0001,
		ST_ADDR = 9'b0_0000_0010,
		ST_ACK_A = 9'b0_0000_0100,
		ST_PTR = 9'b0_0000_1000,
		ST_ACK_P = 9'b0_0001_0000,
		ST_WDATA = 9'b0_0010_0000,
		ST_ACK_W = 9'b0_0100_0000,
		ST_RDATA = 9'b0_1000_0000,
		ST_RACK = 9'b1_0000_0000
	} bmc_state_t;

endpackage

// ---- rtl/bmc_stuck_timer.sv ----
// Stuck-low timer for the shared downstream bus nodes.
`timescale 1ns/100ps
`default_nettype none
module bmc_stuck_timer #(
	parameter int CYC_30 = bmc_pkg::TMO_30_CYC,
	parameter int CYC_15 = bmc_pkg::TMO_15_CYC,
	parameter int CYC_7P5 = bmc_pkg::TMO_7P5_CYC
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic run_i,
	input wire logic bus_low_i,
	input wire logic [1:0] select_i,
	output logic expired_o
);

	logic [bmc_pkg::TMO_CNT_W-1:0] cnt_q;
	logic [bmc_pkg::TMO_CNT_W-1:0] cnt_d;
	logic exp_q;
	logic exp_d;

	function automatic logic [bmc_pkg::TMO_CNT_W-1:0] limit_of(
		input logic [1:0] sel);
		if (sel == bmc_pkg::TMO_SEL_30)
			limit_of = bmc_pkg::TMO_CNT_W'(CYC_30 - 1);
		else if (sel == bmc_pkg::TMO_SEL_15)
			limit_of = bmc_pkg::TMO_CNT_W'(CYC_15 - 1);
		else
			limit_of = bmc_pkg::TMO_CNT_W'(CYC_7P5 - 1);
	endfunction

	// The count restarts as soon as the bus is seen high again.
	always_comb
	begin
		cnt_d = cnt_q;
		exp_d = exp_q;
		if (!run_i || !bus_low_i)
		begin
			cnt_d = '0;
			exp_d = 1'b0;
		end
		else if (cnt_q == limit_of(select_i))
			exp_d = 1'b1;
		else
			cnt_d = cnt_q + 1'b1;
	end

	always_ff @(posedge clock_i)
	begin
		if (!reset_n_i)
		begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign expired_o = exp_q;

endmodule
`default_nettype wire
